// ==== design/regconv_pkg.sv ====
// Package: constants for the register access convention bank
package regconv_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_CMD = 4'h2;
  localparam logic [3:0] OFS_FLAGCLR = 4'h3;
  localparam logic [3:0] OFS_FLAGSET = 4'h4;
  localparam logic [3:0] OFS_DBGCTRL = 4'h5;
  localparam logic [3:0] OFS_SCRATCH = 4'h6;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_DBG = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  // Field layout: CTRL[7] reserved, CTRL[1:0] mode field (2'b11 reserved)
  localparam logic [7:0] CTRL_MASK = 8'h7f;
  localparam logic [7:0] DBG_MASK = 8'h01;
  localparam logic [1:0] MODE_RESERVED = 2'h3;
  localparam int MODE_LSB = 0;
  // Status layout: [1:0] mode in use, [7:2] event counter
  localparam int CNT_LSB = 2;
endpackage : regconv_pkg

// ==== design/regconv_store.sv ====
// File: small register store with registered read data
`timescale 1ns/100ps
`default_nettype none
module regconv_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic soft_rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_word
      always_ff @(posedge MCLK or negedge RST_N)
      begin
        if (!RST_N)
          mem[i] <= '0;
        else if (soft_rst)
          mem[i] <= '0;
        else if (we && waddr == AW'(i))
          mem[i] <= wdata;
      end
    end
  endgenerate
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      rdata <= '0;
    else if (soft_rst)
      rdata <= '0;
    // Write-through so a read on the next edge never sees the old word
    else if (we && waddr == raddr)
      rdata <= wdata;
    else
      rdata <= mem[raddr];
  end
endmodule : regconv_store
`default_nettype wire

// ==== design/regconv_bank.sv ====
// File: example peripheral register bank following the access conventions
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: Read/write bits read back the last written value.
// R2: Read-only bits report state; writes leave them unchanged.
// R3: Write-only bits accept writes; read value is unspecified.
// R4: Reserved bits always read as zero.
// R5: Software writes zero into reserved bits.
// R6: Software never writes a reserved encoding into a field.
// R7: Read-only fields never show a reserved encoding.
// R8: Power and soft reset restore reset values, except debug control.
// R9: A one written to the clear member zeroes the shared bit.
// R10: A one written to the set member sets the shared bit.
// R11: Both members of a pair read the same shared value.
// R12: Simultaneous set and clear: clear wins.
// R13: Zero bits written to either member leave shared bits unchanged.
module regconv_bank (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic SOFT_RST,
  input wire logic WR_EN,
  input wire logic [3:0] WR_ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic SET_WR_EN,
  input wire logic [7:0] SET_DATA,
  input wire logic CLR_WR_EN,
  input wire logic [7:0] CLR_DATA,
  input wire logic RD_EN,
  input wire logic [3:0] RD_ADDR,
  input wire logic EVENT_IN,
  output logic [7:0] RD_DATA,
  output logic [7:0] FLAGS,
  output logic [1:0] MODE,
  output logic DBG_FREEZE,
  output logic [7:0] CMD_PULSE
);
  logic [7:0] ctrl;
  logic [7:0] flags;
  logic [7:0] dbg;
  logic [5:0] count;
  logic [1:0] mode_used;
  logic [7:0] cmd;
  logic [7:0] scratch_rd;
  logic [7:0] next_flags;
  logic [7:0] next_rd;
  logic [7:0] sel_rd;
  logic [7:0] status_val;
  logic [7:0] ctrl_wdata;
  logic [1:0] mode_field;
  logic ev_s1;
  logic ev_s2;
  logic ev_s3;
  logic ev_rise;
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_dbg;
  logic wr_scr;
  logic set_hit;
  logic clr_hit;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic scr_sel;

  // Write decode
  assign wr_ctrl = WR_EN && (WR_ADDR == regconv_pkg::OFS_CTRL);
  assign wr_cmd = WR_EN && (WR_ADDR == regconv_pkg::OFS_CMD);
  assign wr_dbg = WR_EN && (WR_ADDR == regconv_pkg::OFS_DBGCTRL);
  assign wr_scr = WR_EN && (WR_ADDR == regconv_pkg::OFS_SCRATCH);
  // Pair members may arrive on the shared port or the dedicated strobes
  assign set_hit = WR_EN && (WR_ADDR == regconv_pkg::OFS_FLAGSET);
  assign clr_hit = WR_EN && (WR_ADDR == regconv_pkg::OFS_FLAGCLR);
  assign set_bits = (set_hit ? WR_DATA : 8'h00) | (SET_WR_EN ? SET_DATA : 8'h00);
  assign clr_bits = (clr_hit ? WR_DATA : 8'h00) | (CLR_WR_EN ? CLR_DATA : 8'h00);

  // Clear applied after set, so clear wins; zero bits leave state alone
  assign next_flags = (flags | set_bits) & ~clr_bits; // see R9, see R10, see R12, see R13

  // Flag checks leave out soft reset, which overrides both members
  a_clear_wins: assert property ( // see R12
    @(posedge MCLK) disable iff (!RST_N)
    !SOFT_RST && (clr_bits != 8'h00) |=> ((flags & $past(clr_bits)) == 8'h00))
    else $error("cleared flag bit still set");
  a_set_takes: assert property ( // see R10
    @(posedge MCLK) disable iff (!RST_N)
    !SOFT_RST && (set_bits & ~clr_bits) != 8'h00
    |=> ((flags & $past(set_bits & ~clr_bits)) == $past(set_bits & ~clr_bits)))
    else $error("set flag bit not set");
  a_zero_keeps: assert property ( // see R13
    @(posedge MCLK) disable iff (!RST_N)
    !SOFT_RST |=> ((flags ^ $past(flags)) & ~($past(set_bits) | $past(clr_bits))) == 8'h00)
    else $error("untouched flag bit changed");
  c_set_clear_same: cover property (@(posedge MCLK) disable iff (!RST_N)
    (set_bits & clr_bits) != 8'h00);

  // Reserved bit dropped on write so it can never read back non-zero
  assign ctrl_wdata = WR_DATA & regconv_pkg::CTRL_MASK; // see R4

  // Reserved mode encodings are software's duty; hardware still guards status
  assign mode_field = ctrl[regconv_pkg::MODE_LSB +: 2]; // see R6

  // Event input is asynchronous; third stage feeds the edge detector only
  assign ev_rise = ev_s2 && !ev_s3;

  assign status_val = {count, mode_used}; // see R2
  assign scr_sel = RD_ADDR == regconv_pkg::OFS_SCRATCH;

  // Read decode: write-only CMD reads zero by choice, unmapped reads zero
  always_comb
  begin
    if (RD_ADDR == regconv_pkg::OFS_CTRL)
      sel_rd = ctrl & regconv_pkg::CTRL_MASK; // see R1, see R4
    else if (RD_ADDR == regconv_pkg::OFS_STATUS)
      sel_rd = status_val; // see R2
    else if (RD_ADDR == regconv_pkg::OFS_CMD)
      sel_rd = 8'h00; // see R3
    else if (RD_ADDR == regconv_pkg::OFS_FLAGCLR || RD_ADDR == regconv_pkg::OFS_FLAGSET)
      sel_rd = flags; // see R11
    else if (RD_ADDR == regconv_pkg::OFS_DBGCTRL)
      sel_rd = dbg & regconv_pkg::DBG_MASK; // see R4
    else if (scr_sel)
      sel_rd = scratch_rd; // see R1
    else
      sel_rd = 8'h00;
  end
  // Read data stands until the next read so a slow consumer can pick it up late
  assign next_rd = RD_EN ? sel_rd : RD_DATA;

  a_pair_same: assert property ( // see R11
    @(posedge MCLK) disable iff (!RST_N)
    RD_EN && (RD_ADDR == regconv_pkg::OFS_FLAGSET || RD_ADDR == regconv_pkg::OFS_FLAGCLR)
    |=> RD_DATA == $past(flags))
    else $error("pair read differs from shared value");
  a_reserved_zero: assert property ( // see R4
    @(posedge MCLK) disable iff (!RST_N)
    $past(RD_EN) && $past(RD_ADDR) == regconv_pkg::OFS_CTRL |-> RD_DATA[7] == 1'b0)
    else $error("reserved bit reads non-zero");
  a_dbg_reserved: assert property ( // see R4
    @(posedge MCLK) disable iff (!RST_N)
    $past(RD_EN) && $past(RD_ADDR) == regconv_pkg::OFS_DBGCTRL |-> RD_DATA[7:1] == 7'h00)
    else $error("reserved debug bits read non-zero");
  a_status_legal: assert property ( // see R7
    @(posedge MCLK) disable iff (!RST_N)
    $past(RD_EN) && $past(RD_ADDR) == regconv_pkg::OFS_STATUS
    |-> RD_DATA[1:0] != regconv_pkg::MODE_RESERVED)
    else $error("status shows reserved mode");
  a_read_holds: assert property ( // see R1
    @(posedge MCLK) disable iff (!RST_N)
    !RD_EN |=> $stable(RD_DATA))
    else $error("read data changed without a read");

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      ev_s3 <= 1'b0;
    end
    else
    begin
      ev_s1 <= EVENT_IN;
      ev_s2 <= ev_s1;
      ev_s3 <= ev_s2;
    end
  end

  // Control and flag state; soft reset restores reset values
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl <= regconv_pkg::RST_CTRL; // see R8
      flags <= regconv_pkg::RST_FLAGS;
      cmd <= 8'h00;
    end
    else if (SOFT_RST)
    begin
      ctrl <= regconv_pkg::RST_CTRL; // see R8
      flags <= regconv_pkg::RST_FLAGS;
      cmd <= 8'h00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= ctrl_wdata; // see R1
      flags <= next_flags;
      cmd <= wr_cmd ? WR_DATA : 8'h00; // see R3
    end
  end

  a_ctrl_readback: assert property ( // see R1
    @(posedge MCLK) disable iff (!RST_N)
    wr_ctrl && !SOFT_RST ##1 (RD_EN && RD_ADDR == regconv_pkg::OFS_CTRL && !wr_ctrl && !SOFT_RST)
    |=> RD_DATA == ($past(WR_DATA, 2) & regconv_pkg::CTRL_MASK))
    else $error("control readback mismatch");
  a_scratch_rw: assert property ( // see R1
    @(posedge MCLK) disable iff (!RST_N)
    wr_scr && !SOFT_RST ##1 (RD_EN && scr_sel && !wr_scr && !SOFT_RST)
    |=> RD_DATA == $past(WR_DATA, 2))
    else $error("scratch readback mismatch");
  a_soft_reset: assert property ( // see R8
    @(posedge MCLK) disable iff (!RST_N)
    SOFT_RST && !wr_dbg |=> ctrl == regconv_pkg::RST_CTRL && flags == regconv_pkg::RST_FLAGS
    && dbg == $past(dbg))
    else $error("soft reset result wrong");
  // Command value is a one-cycle strobe; it never reaches the read path
  a_cmd_load: assert property ( // see R3
    @(posedge MCLK) disable iff (!RST_N)
    wr_cmd && !SOFT_RST |=> CMD_PULSE == $past(WR_DATA))
    else $error("command value not presented");
  a_cmd_clears: assert property ( // see R3
    @(posedge MCLK) disable iff (!RST_N)
    !wr_cmd |=> CMD_PULSE == 8'h00)
    else $error("command pulse outlived its cycle");
  c_soft_rst: cover property (@(posedge MCLK) disable iff (!RST_N) SOFT_RST && dbg[0]);
  c_write_read: cover property (@(posedge MCLK) disable iff (!RST_N) wr_ctrl ##1 RD_EN);

  // Debug control survives the peripheral soft reset
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      dbg <= regconv_pkg::RST_DBG; // see R8
    else if (wr_dbg)
      dbg <= WR_DATA & regconv_pkg::DBG_MASK;
  end

  // Read-only status: counter and mode actually in use
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      count <= '0;
      mode_used <= 2'h0;
    end
    else if (SOFT_RST)
    begin
      count <= '0;
      mode_used <= 2'h0;
    end
    else
    begin
      if (ev_rise && !dbg[0])
        count <= count + 6'h01;
      // A reserved request keeps the last legal mode
      if (mode_field != regconv_pkg::MODE_RESERVED)
        mode_used <= mode_field; // see R7
    end
  end

  // Counter wraps silently at 63; software must sample it often enough
  a_event_count: assert property ( // see R2
    @(posedge MCLK) disable iff (!RST_N)
    ev_rise && !dbg[0] && !SOFT_RST |=> count == $past(count) + 6'h01)
    else $error("event not counted");
  a_mode_legal: assert property ( // see R7
    @(posedge MCLK) disable iff (!RST_N)
    MODE != regconv_pkg::MODE_RESERVED)
    else $error("reserved mode encoding shown");
  a_status_ro: assert property ( // see R2
    @(posedge MCLK) disable iff (!RST_N)
    WR_EN && WR_ADDR == regconv_pkg::OFS_STATUS && !SOFT_RST && !ev_rise && $stable(ctrl)
    |=> $stable(count))
    else $error("status changed by write");
  a_freeze_count: assert property ( // see R2
    @(posedge MCLK) disable iff (!RST_N)
    dbg[0] && !SOFT_RST |=> $stable(count))
    else $error("counter moved while frozen");
  c_event: cover property (@(posedge MCLK) disable iff (!RST_N) ev_rise);
  c_bad_mode: cover property (@(posedge MCLK) disable iff (!RST_N)
    mode_field == regconv_pkg::MODE_RESERVED);

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
      RD_DATA <= 8'h00;
    else
      RD_DATA <= next_rd; // see R1
  end

  // Scratch word lives in the store; its data register is the read path
  regconv_store #(
    .WIDTH(8),
    .DEPTH(4),
    .AW(2)
  ) u_store (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .soft_rst(SOFT_RST),
    .we(wr_scr),
    .waddr(2'h0),
    .wdata(WR_DATA),
    .raddr(2'h0),
    .rdata(scratch_rd)
  );

  assign FLAGS = flags;
  assign MODE = mode_used;
  assign DBG_FREEZE = dbg[0];
  assign CMD_PULSE = cmd;

endmodule : regconv_bank
`default_nettype wire

// ==== dv/regconv_bank_tb.sv ====
// Testbench: directed scenarios for the register access convention bank
`timescale 1ns/100ps
`default_nettype none
module regconv_bank_tb;
  logic MCLK = 1'b0;
  logic RST_N = 1'b0;
  logic SOFT_RST = 1'b0;
  logic WR_EN = 1'b0;
  logic [3:0] WR_ADDR = 4'h0;
  logic [7:0] WR_DATA = 8'h00;
  logic SET_WR_EN = 1'b0;
  logic [7:0] SET_DATA = 8'h00;
  logic CLR_WR_EN = 1'b0;
  logic [7:0] CLR_DATA = 8'h00;
  logic RD_EN = 1'b0;
  logic [3:0] RD_ADDR = 4'h0;
  logic EVENT_IN = 1'b0;
  logic [7:0] RD_DATA;
  logic [7:0] FLAGS;
  logic [1:0] MODE;
  logic DBG_FREEZE;
  logic [7:0] CMD_PULSE;
  int n_errors = 0;
  int n_checks = 0;

  regconv_bank u_regconv_bank (.MCLK(MCLK), .RST_N(RST_N), .SOFT_RST(SOFT_RST), .WR_EN(WR_EN),
    .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .SET_WR_EN(SET_WR_EN), .SET_DATA(SET_DATA),
    .CLR_WR_EN(CLR_WR_EN), .CLR_DATA(CLR_DATA), .RD_EN(RD_EN), .RD_ADDR(RD_ADDR),
    .EVENT_IN(EVENT_IN), .RD_DATA(RD_DATA), .FLAGS(FLAGS), .MODE(MODE),
    .DBG_FREEZE(DBG_FREEZE), .CMD_PULSE(CMD_PULSE));

  initial
  begin
    forever #50 MCLK = ~MCLK;
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  // Every transfer starts on a fresh edge so no strobe is driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK);
    WR_EN <= 1'b1;
    WR_ADDR <= a;
    WR_DATA <= d;
    @(posedge MCLK);
    WR_EN <= 1'b0;
  endtask : wr

  task automatic rc(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge MCLK);
    RD_EN <= 1'b1;
    RD_ADDR <= a;
    @(posedge MCLK);
    RD_EN <= 1'b0;
    @(negedge MCLK);
    chk(n, RD_DATA, e);
  endtask : rc

  task automatic sc(input logic se, input logic [7:0] sd, input logic ce, input logic [7:0] cd,
                    input logic [7:0] e);
    @(posedge MCLK);
    SET_WR_EN <= se;
    SET_DATA <= sd;
    CLR_WR_EN <= ce;
    CLR_DATA <= cd;
    @(posedge MCLK);
    SET_WR_EN <= 1'b0;
    CLR_WR_EN <= 1'b0;
    @(negedge MCLK);
    chk("FLAGS", FLAGS, e);
  endtask : sc

  // Pulses wide enough for the input synchroniser, then time to settle
  task automatic ev(input int n);
    repeat (n)
    begin
      @(posedge MCLK);
      EVENT_IN <= 1'b1;
      repeat (2) @(posedge MCLK);
      EVENT_IN <= 1'b0;
      repeat (2) @(posedge MCLK);
    end
    repeat (4) @(posedge MCLK);
  endtask : ev

  task automatic t_reset();
    @(negedge MCLK);
    chk("FLAGS", FLAGS, regconv_pkg::RST_FLAGS);
    chk("MODE", {6'h00, MODE}, 8'h00);
    rc(regconv_pkg::OFS_CTRL, regconv_pkg::RST_CTRL, "CTRL");
    rc(regconv_pkg::OFS_STATUS, 8'h00, "STATUS");
    rc(regconv_pkg::OFS_FLAGSET, regconv_pkg::RST_FLAGS, "FLAGSET");
    rc(regconv_pkg::OFS_DBGCTRL, regconv_pkg::RST_DBG, "DBGCTRL");
    rc(4'hf, 8'h00, "unmapped");
    rc(regconv_pkg::OFS_SCRATCH, regconv_pkg::RST_SCRATCH, "SCRATCH");
  endtask : t_reset

  task automatic t_event();
    ev(3);
    rc(regconv_pkg::OFS_STATUS, 8'h0c, "STATUS count");
    wr(regconv_pkg::OFS_DBGCTRL, 8'h01);
    ev(2);
    rc(regconv_pkg::OFS_STATUS, 8'h0c, "STATUS frozen");
  endtask : t_event

  task automatic t_rw();
    wr(regconv_pkg::OFS_CTRL, 8'hfe);
    rc(regconv_pkg::OFS_CTRL, 8'h7e, "CTRL rsvd");
    chk("MODE", {6'h00, MODE}, 8'h02);
    wr(regconv_pkg::OFS_CTRL, 8'h55);
    rc(regconv_pkg::OFS_CTRL, 8'h55, "CTRL");
    wr(regconv_pkg::OFS_DBGCTRL, 8'hff);
    rc(regconv_pkg::OFS_DBGCTRL, 8'h01, "DBGCTRL rsvd");
    chk("DBG_FREEZE", {7'h00, DBG_FREEZE}, 8'h01);
    wr(regconv_pkg::OFS_DBGCTRL, 8'h00);
    rc(regconv_pkg::OFS_DBGCTRL, 8'h00, "DBGCTRL");
  endtask : t_rw

  // Status holds count 3 and mode 1 from the scenarios before
  task automatic t_ro();
    wr(regconv_pkg::OFS_STATUS, 8'hff);
    rc(regconv_pkg::OFS_STATUS, 8'h0d, "STATUS");
    wr(regconv_pkg::OFS_CTRL, 8'h03);
    rc(regconv_pkg::OFS_STATUS, 8'h0d, "STATUS mode");
    chk("MODE", {6'h00, MODE}, 8'h01);
  endtask : t_ro

  task automatic t_pair();
    sc(1'b1, 8'ha5, 1'b0, 8'hff, 8'ha5);
    rc(regconv_pkg::OFS_FLAGCLR, 8'ha5, "FLAGCLR");
    rc(regconv_pkg::OFS_FLAGSET, 8'ha5, "FLAGSET");
    wr(regconv_pkg::OFS_FLAGCLR, 8'h05);
    rc(regconv_pkg::OFS_FLAGSET, 8'ha0, "FLAGSET clr");
    wr(regconv_pkg::OFS_FLAGSET, 8'h0a);
    rc(regconv_pkg::OFS_FLAGCLR, 8'haa, "FLAGCLR set");
    sc(1'b1, 8'h0f, 1'b1, 8'h03, 8'hac);
    sc(1'b1, 8'h00, 1'b1, 8'h00, 8'hac);
    sc(1'b0, 8'hff, 1'b1, 8'h84, 8'h28);
  endtask : t_pair

  task automatic t_cmd();
    wr(regconv_pkg::OFS_CMD, 8'h3c);
    @(negedge MCLK);
    chk("CMD_PULSE", CMD_PULSE, 8'h3c);
    @(negedge MCLK);
    chk("CMD_PULSE end", CMD_PULSE, 8'h00);
  endtask : t_cmd

  // Write and read on adjacent edges; the read data must then stand
  task automatic t_b2b(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e,
                       input string n);
    @(posedge MCLK);
    WR_EN <= 1'b1;
    WR_ADDR <= a;
    WR_DATA <= d;
    @(posedge MCLK);
    WR_EN <= 1'b0;
    RD_EN <= 1'b1;
    RD_ADDR <= a;
    @(posedge MCLK);
    RD_EN <= 1'b0;
    @(negedge MCLK);
    chk(n, RD_DATA, e);
    @(negedge MCLK);
    chk(n, RD_DATA, e);
  endtask : t_b2b

  // Debug control must survive the peripheral reset while the rest clears
  task automatic t_soft();
    wr(regconv_pkg::OFS_DBGCTRL, 8'h01);
    wr(regconv_pkg::OFS_CTRL, 8'h12);
    @(posedge MCLK);
    SOFT_RST <= 1'b1;
    @(posedge MCLK);
    SOFT_RST <= 1'b0;
    @(negedge MCLK);
    chk("FLAGS", FLAGS, regconv_pkg::RST_FLAGS);
    chk("DBG_FREEZE", {7'h00, DBG_FREEZE}, 8'h01);
    rc(regconv_pkg::OFS_CTRL, regconv_pkg::RST_CTRL, "CTRL");
    rc(regconv_pkg::OFS_STATUS, 8'h00, "STATUS");
    rc(regconv_pkg::OFS_DBGCTRL, 8'h01, "DBGCTRL");
    rc(regconv_pkg::OFS_SCRATCH, regconv_pkg::RST_SCRATCH, "SCRATCH");
  endtask : t_soft

  initial
  begin
    repeat (5) @(posedge MCLK);
    RST_N <= 1'b1;
    @(posedge MCLK);
    t_reset();
    t_event();
    t_rw();
    t_ro();
    t_pair();
    t_cmd();
    t_b2b(regconv_pkg::OFS_CTRL, 8'h21, 8'h21, "CTRL b2b");
    t_b2b(regconv_pkg::OFS_SCRATCH, 8'h9c, 8'h9c, "SCRATCH b2b");
    t_soft();
    print_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge MCLK);
    n_errors++;
    print_verdict();
  end
endmodule : regconv_bank_tb
`default_nettype wire
